// File: dv/acl_host_model.sv
// Host side of the audio serial interface: takes transmit words, sends receive words.
// Assumes the block's clock; the bench steers the stalls through hold_i and slow_i.
`timescale 1ns/1ps
module acl_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hold_i,
    input  wire logic        slow_i,
    input  wire logic        tx_valid_i,
    output logic             tx_ready_o,
    input  wire logic [31:0] tx_data_i,
    output logic             rx_valid_o,
    input  wire logic        rx_ready_i,
    output logic      [31:0] rx_data_o
);
    logic [31:0] got_q[$];

    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o  = 32'h0;
    end

    ////////////////////////////////////////////////////////////////
    // Sink: full rate, every other cycle, or stopped
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_ready_o <= 1'b0;
            got_q.delete();
        end else begin
            if (tx_valid_i === 1'b1 && tx_ready_o)
                got_q.push_back(tx_data_i);
            tx_ready_o <= !hold_i && (!slow_i || !tx_ready_o);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Source: word held until taken, then the lines flip
    task automatic send(input logic [31:0] word);
        int n;
        n = 0;
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o  <= word;
        do begin
            @(posedge clk_i);
            n++;
        end while (rx_ready_i !== 1'b1 && n < 200);
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~word;
    endtask
endmodule

// File: dv/audio_companding_loopback_tb.sv
// Self-checking bench for the companding and loopback block.
// Assumes a 100 MHz clock, synchronous active-high reset and the host model beside it.
`timescale 1ns/1ps
module audio_companding_loopback_tb
    import acl_pkg::*;
;
    typedef struct packed {
        logic [1:0]  path;
        logic [6:0]  ctrl;
        logic [31:0] din;
        logic [31:0] dexp;
    } acl_row_t;

    localparam logic [7:0] A_CTRL = {ACL_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {ACL_IDX_STAT, 2'b00};
    localparam logic [7:0] A_WLEN = {ACL_IDX_WLEN, 2'b00};

    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        wb_cyc_i    = 1'b0;
    logic        wb_stb_i    = 1'b0;
    logic        wb_we_i     = 1'b0;
    logic [7:0]  wb_adr_i    = 8'h00;
    logic [3:0]  wb_sel_i    = 4'h0;
    logic [31:0] wb_dat_i    = 32'h0;
    logic        adc_valid_i = 1'b0;
    logic [15:0] adc_data_i  = 16'h0;
    logic        dac_ready_i = 1'b1;
    logic        hold        = 1'b0;
    logic        slow        = 1'b1;
    logic        dac_hold    = 1'b0;
    logic [31:0] wb_dat_o, tx_data_o, rx_data_i;
    logic [15:0] dac_data_o;
    logic        wb_ack_o, adc_ready_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o, dac_valid_o;
    logic [31:0] dac_q[$];
    logic [31:0] v;
    int          failures    = 0;
    int          comparisons = 0;

    // Paths: 0 adc->tx, 1 rx->dac, 2 adc->dac, 3 rx->tx
    acl_row_t rows [26] = '{
        '{2'd0, 7'h00, 32'h1234, 32'h12340000}, '{2'd0, 7'h02, 32'h8001, 32'h80010000},
        '{2'd0, 7'h04, 32'h0000, 32'hff000000}, '{2'd0, 7'h04, 32'h7fff, 32'h80000000},
        '{2'd0, 7'h04, 32'h1000, 32'haf000000}, '{2'd0, 7'h04, 32'hf000, 32'h2f000000},
        '{2'd0, 7'h06, 32'h0000, 32'hd5000000}, '{2'd0, 7'h06, 32'h1000, 32'h85000000},
        '{2'd0, 7'h06, 32'heffc, 32'h05000000}, '{2'd0, 7'h06, 32'h7fff, 32'haa000000},
        '{2'd0, 7'h20, 32'h1234, 32'h12000000}, '{2'd0, 7'h24, 32'h1000, 32'haf000000},
        '{2'd1, 7'h00, 32'habcd1234, 32'habcd}, '{2'd1, 7'h08, 32'h5678ffff, 32'h5678},
        '{2'd1, 7'h10, 32'hff000000, 32'h0000}, '{2'd1, 7'h10, 32'haf000000, 32'h0ffc},
        '{2'd1, 7'h10, 32'h2f000000, 32'hf004}, '{2'd1, 7'h18, 32'hd5000000, 32'h0008},
        '{2'd1, 7'h18, 32'h85000000, 32'h1080}, '{2'd1, 7'h18, 32'h05000000, 32'hef80},
        '{2'd1, 7'h18, 32'haa000000, 32'h7e00}, '{2'd2, 7'h15, 32'h1000, 32'h0ffc},
        '{2'd2, 7'h1f, 32'h1000, 32'h1080}, '{2'd3, 7'h40, 32'hdeadbeef, 32'hdeadbeef},
        '{2'd1, 7'h41, 32'hdeadbeef, 32'hdead}, '{2'd1, 7'h20, 32'habcd1234, 32'hab00}
    };

    acl_codec_top acl_codec_top_i (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .adc_valid_i, .adc_ready_o, .adc_data_i, .tx_valid_o, .tx_ready_i, .tx_data_o,
        .rx_valid_i, .rx_ready_o, .rx_data_i, .dac_valid_o, .dac_ready_i, .dac_data_o
    );

    acl_host_model acl_host_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .slow_i(slow),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o),
        .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o), .rx_data_o(rx_data_i)
    );

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (dac_valid_o === 1'b1 && dac_ready_i === 1'b1)
            dac_q.push_back({16'h0, dac_data_o});
        dac_ready_i <= !dac_hold;
    end

    task automatic report_and_stop();
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] rd;
        wb(1'b0, a, 32'h0, 4'hf, rd);
        check(rd, want);
    endtask

    task automatic push(input logic [15:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        adc_valid_i <= 1'b1;
        adc_data_i  <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (adc_ready_o !== 1'b1 && n < 200);
        adc_valid_i <= 1'b0;
        adc_data_i  <= ~s;
    endtask

    function automatic int qsize(input bit d);
        return d ? dac_q.size() : acl_host_model_i.got_q.size();
    endfunction

    task automatic take(input bit d, input logic [31:0] want);
        logic [31:0] got;
        int          n;
        got = 32'hx;
        n = 0;
        while (qsize(d) == 0 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (qsize(d) != 0)
            got = d ? dac_q.pop_front() : acl_host_model_i.got_q.pop_front();
        check(got, want);
    endtask

    task automatic pulse_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(1'b1, A_CTRL, {25'h0, rows[i].ctrl}, 4'h1, v);
            if (rows[i].path[0])
                acl_host_model_i.send(rows[i].din);
            else
                push(rows[i].din[15:0]);
            take(^rows[i].path, rows[i].dexp);
            repeat (4) @(posedge clk_i);
            check(32'(qsize(0) + qsize(1)), 32'h0);
        end
        // Byte mode beats the widest word length
        wb(1'b1, A_WLEN, 32'h3, 4'h1, v);
        wb(1'b1, A_CTRL, 32'h20, 4'h1, v);
        push(16'ha5c3);
        take(1'b0, 32'ha5000000);
        wb(1'b1, A_CTRL, 32'h0, 4'h1, v);
        push(16'ha5c3);
        take(1'b0, 32'ha5c30000);
        // Expansion while the converter stalls
        wb(1'b1, A_CTRL, 32'h10, 4'h1, v);
        dac_hold <= 1'b1;
        acl_host_model_i.send(32'h80000000);
        repeat (3) @(posedge clk_i);
        check({30'h0, dac_valid_o, rx_ready_o}, 32'h2);
        dac_hold <= 1'b0;
        take(1'b1, 32'h7d7c);
        // Fill the buffer against a stopped host, then drain it slowly
        wb(1'b1, A_CTRL, 32'h0, 4'h1, v);
        hold <= 1'b1;
        for (int i = 0; i < ACL_FIFO_DEPTH; i++)
            push(16'h0100 + 16'(i));
        @(posedge clk_i);
        check({31'h0, adc_ready_o}, 32'h0);
        rdchk(A_STAT, 32'h30);
        hold <= 1'b0;
        for (int i = 0; i < ACL_FIFO_DEPTH; i++)
            take(1'b0, {16'h0100 + 16'(i), 16'h0});
        rdchk(A_STAT, 32'h40);
        // Register access, unmapped place and reset values
        wb(1'b1, A_CTRL, 32'h1ff, 4'hf, v);
        rdchk(A_CTRL, 32'h7f);
        wb(1'b1, A_CTRL, 32'h0, 4'h0, v);
        rdchk(A_CTRL, 32'h7f);
        wb(1'b1, 8'h40, 32'hff, 4'hf, v);
        rdchk(8'h40, 32'h0);
        pulse_reset();
        rdchk(A_CTRL, 32'h0);
        rdchk(A_WLEN, 32'h0);
        push(16'h4321);
        take(1'b0, 32'h43210000);
        report_and_stop();
    end
endmodule

// File: include/acl_pkg.sv
// Constants and types shared by the companding and loopback block.
// Assumes a 100 MHz single clock and a 32-bit classic Wishbone register bus.
package acl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] ACL_IDX_CTRL = 6'h05;
    localparam logic [5:0] ACL_IDX_STAT = 6'h06;
    localparam logic [5:0] ACL_IDX_WLEN = 6'h07;

    // Control field positions and reset values
    localparam int unsigned ACL_B_TX_LOOP = 0;
    localparam int unsigned ACL_B_TX_COMP = 1;
    localparam int unsigned ACL_B_RX_COMP = 3;
    localparam int unsigned ACL_B_BYTE8   = 5;
    localparam int unsigned ACL_B_RX_LOOP = 6;
    localparam int unsigned ACL_CTRL_W    = 7;
    localparam logic [6:0]  ACL_CTRL_RST  = 7'h00;
    localparam logic [1:0]  ACL_WLEN_RST  = 2'h0;

    // Status field positions
    localparam int unsigned ACL_S_LEVEL = 0;
    localparam int unsigned ACL_S_FULL  = 5;
    localparam int unsigned ACL_S_EMPTY = 6;
    localparam int unsigned ACL_S_BYTE  = 7;
    localparam int unsigned ACL_S_DACV  = 8;

    // Word masks, audio left justified in a 32-bit word
    localparam logic [31:0] ACL_MASK_8  = 32'hff000000;
    localparam logic [31:0] ACL_MASK_16 = 32'hffff0000;
    localparam logic [31:0] ACL_MASK_20 = 32'hfffff000;
    localparam logic [31:0] ACL_MASK_24 = 32'hffffff00;
    localparam logic [31:0] ACL_MASK_32 = 32'hffffffff;

    // Companding constants
    localparam logic [7:0]  ACL_MU_INV  = 8'hff;
    localparam logic [7:0]  ACL_A_INV   = 8'h55;
    localparam logic [13:0] ACL_MU_CLIP = 14'h1fde;
    localparam logic [13:0] ACL_MU_BIAS = 14'h0021;
    localparam logic [15:0] ACL_MU_DBIAS = 16'h0084;
    localparam logic [15:0] ACL_A_SEG1  = 16'h0108;
    localparam logic [15:0] ACL_A_SEG0  = 16'h0008;

    localparam int unsigned ACL_WORD_W     = 32;
    localparam int unsigned ACL_FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        ACL_COMP_OFF,
        ACL_COMP_RSVD,
        ACL_COMP_MU,
        ACL_COMP_A
    } acl_comp_t;

endpackage

// File: include/acl_stream_if.sv
// Valid/ready word stream between the block's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface acl_stream_if #(parameter int unsigned W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: logic/acl_codec_top.sv
// Companding and digital loopback between converter streams and the audio interface.
// Assumes same-clock stream partners and a classic Wishbone master.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Independent companding on transmit and receive paths
// - Selects at 4:3 and 2:1; 01 reserved
// - Byte mode overrides normal interface word length
// - Receive loopback feeds received words into transmit
// - Transmit loopback feeds transmit words to converter
// - Invert codes: mu all bits, A even bits
// - Code sits in top eight word bits
// - Compress 13/12-bit linear to 8, expand back
// - Eight segments, finer steps at low amplitude
// - Code: sign bit7, exponent 6:4, mantissa 3:0
// - Piecewise G.711 laws, mu 255, A 87.6
// - Bit 5 forces byte words, else normal
module acl_codec_top
    import acl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        adc_valid_i,
    output logic             adc_ready_o,
    input  wire logic [15:0] adc_data_i,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output logic      [31:0] tx_data_o,
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    input  wire logic [31:0] rx_data_i,
    output logic             dac_valid_o,
    input  wire logic        dac_ready_i,
    output logic      [15:0] dac_data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Word length decode, shared by both directions
    function automatic logic [31:0] word_mask(input logic byte8, input logic [1:0] wl);
        logic [31:0] m;
        case (wl)
            2'h0:    m = ACL_MASK_16;
            2'h1:    m = ACL_MASK_20;
            2'h2:    m = ACL_MASK_24;
            default: m = ACL_MASK_32;
        endcase
        if (byte8) begin
            m = ACL_MASK_8;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control state
    logic [ACL_CTRL_W-1:0] ctrl;
    logic [1:0]            interface_word_length;
    logic                  tx_loop;
    logic                  rx_loop;
    logic                  force_byte_word;
    acl_comp_t             tx_mode;
    acl_comp_t             rx_mode;
    logic                  tx_comp_on;
    logic                  rx_comp_on;
    logic [31:0]           len_mask;

    assign tx_loop         = ctrl[ACL_B_TX_LOOP];
    assign rx_loop         = ctrl[ACL_B_RX_LOOP];
    assign force_byte_word = ctrl[ACL_B_BYTE8];
    assign tx_mode         = acl_comp_t'(ctrl[ACL_B_TX_COMP +: 2]);
    assign rx_mode         = acl_comp_t'(ctrl[ACL_B_RX_COMP +: 2]);
    // Reserved select code behaves as off
    assign tx_comp_on      = (tx_mode == ACL_COMP_MU) || (tx_mode == ACL_COMP_A);
    assign rx_comp_on      = (rx_mode == ACL_COMP_MU) || (rx_mode == ACL_COMP_A);
    assign len_mask        = word_mask(force_byte_word, interface_word_length);

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after request, write at the ack edge
    logic        bus_req;
    logic        bus_take;
    logic [5:0]  reg_idx;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_wlen;
    logic        wr_now;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;
    logic [4:0]  fifo_level;

    acl_stream_if #(.W(ACL_WORD_W)) fifo_in ();
    acl_stream_if #(.W(ACL_WORD_W)) fifo_out ();

    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign bus_take = bus_req & ~wb_ack_o;
    assign reg_idx  = wb_adr_i[7:2];
    assign hit_ctrl = (reg_idx == ACL_IDX_CTRL);
    assign hit_stat = (reg_idx == ACL_IDX_STAT);
    assign hit_wlen = (reg_idx == ACL_IDX_WLEN);
    assign wr_now   = bus_req & wb_we_i & wb_ack_o;
    assign rd_mux   = hit_ctrl ? 32'(ctrl)
                    : hit_stat ? stat_word
                    : hit_wlen ? 32'(interface_word_length)
                    : '0;

    always_comb begin
        stat_word                       = '0;
        stat_word[ACL_S_LEVEL +: 5]     = fifo_level;
        stat_word[ACL_S_FULL]           = ~fifo_in.ready;
        stat_word[ACL_S_EMPTY]          = ~fifo_out.valid;
        stat_word[ACL_S_BYTE]           = force_byte_word;
        stat_word[ACL_S_DACV]           = dac_valid_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_take;
            wb_dat_o <= bus_take ? rd_mux : wb_dat_o;
        end
    end

    // Control register; bits above the loopback read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl                  <= ACL_CTRL_RST;
            interface_word_length <= ACL_WLEN_RST;
        end else if (wr_now) begin
            if (hit_ctrl && wb_sel_i[0]) begin
                ctrl <= wb_dat_i[ACL_CTRL_W-1:0];
            end
            if (hit_wlen && wb_sel_i[0]) begin
                interface_word_length <= wb_dat_i[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Companding engine
    logic [7:0]  enc_code;
    logic [15:0] dec_lin;
    logic [31:0] dac_src;

    acl_g711 u_g711 (
        .enc_alaw_i (tx_mode == ACL_COMP_A),
        .lin_i      (adc_data_i),
        .code_o     (enc_code),
        .dec_alaw_i (rx_mode == ACL_COMP_A),
        .code_i     (dac_src[31:24]),
        .lin_o      (dec_lin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path into the FIFO
    logic [31:0] tx_word;

    // Code in the top byte, or linear sample, cut to word length
    assign tx_word       = len_mask & (tx_comp_on ? {enc_code, 24'h000000} : {adc_data_i, 16'h0000});
    // Received words replace converter samples on the transmit side
    assign fifo_in.valid = rx_loop ? rx_valid_i : adc_valid_i;
    assign fifo_in.data  = rx_loop ? rx_data_i : tx_word;
    assign adc_ready_o   = ~rx_loop & fifo_in.ready;

    acl_fifo #(
        .WIDTH (ACL_WORD_W),
        .DEPTH (ACL_FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .in_s    (fifo_in),
        .out_s   (fifo_out),
        .level_o (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit output and receive path toward the output converter
    logic        dac_in_valid;
    logic        dac_in_ready;
    logic        dac_take;
    logic [31:0] dac_word;
    logic [15:0] next_dac;

    // Transmit words go to the converter instead of the interface
    assign tx_valid_o     = ~tx_loop & fifo_out.valid;
    assign tx_data_o      = fifo_out.data;
    assign fifo_out.ready = tx_loop ? dac_in_ready : tx_ready_i;
    assign dac_src        = tx_loop ? fifo_out.data : rx_data_i;
    assign dac_in_valid   = tx_loop ? fifo_out.valid : (~rx_loop & rx_valid_i);
    assign dac_in_ready   = ~dac_valid_o | dac_ready_i;
    assign rx_ready_o     = rx_loop ? fifo_in.ready : (~tx_loop & dac_in_ready);
    assign dac_take       = dac_in_valid & dac_in_ready;
    assign dac_word       = dac_src & len_mask;
    // Expanded code or plain linear top half
    assign next_dac       = rx_comp_on ? dec_lin : dac_word[31:16];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_valid_o <= 1'b0;
            dac_data_o  <= '0;
        end else if (dac_take) begin
            dac_valid_o <= 1'b1;
            dac_data_o  <= next_dac;
        end else if (dac_ready_i) begin
            dac_valid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic adc_take;
    assign adc_take = adc_valid_i & adc_ready_o;

    rst_ctrl_a: assert property (disable iff (1'b0)
        rst_i |=> (ctrl == ACL_CTRL_RST) && !tx_valid_o && !dac_valid_o)
        else $error("control not cleared by reset");

    reserved_off_a: assert property (
        adc_take && tx_mode == ACL_COMP_RSVD
        |-> fifo_in.data == (len_mask & {adc_data_i, 16'h0000}))
        else $error("reserved select did not pass linear data");

    mu_zero_a: assert property (
        adc_take && tx_mode == ACL_COMP_MU && adc_data_i == 16'h0000
        |-> fifo_in.data[31:24] == ACL_MU_INV)
        else $error("mu-law zero code not fully inverted");

    a_zero_a: assert property (
        adc_take && tx_mode == ACL_COMP_A && adc_data_i == 16'h0000
        |-> fifo_in.data[31:24] == (8'h80 ^ ACL_A_INV))
        else $error("A-law zero code not even-bit inverted");

    mu_peak_a: assert property (
        adc_take && tx_mode == ACL_COMP_MU && adc_data_i == 16'h7fff
        |-> fifo_in.data[31:24] == 8'h80)
        else $error("mu-law full scale not in top segment");

    code_top_a: assert property (
        adc_take && tx_comp_on |-> fifo_in.data[23:0] == 24'h000000)
        else $error("compressed code not in top byte only");

    sign_bit_a: assert property (
        adc_take && tx_comp_on |-> fifo_in.data[31] == ~adc_data_i[15])
        else $error("code sign bit wrong");

    byte_force_a: assert property (
        adc_take && force_byte_word && !tx_comp_on
        |-> fifo_in.data == {adc_data_i[15:8], 24'h000000})
        else $error("byte mode did not force 8-bit words");

    rx_loop_a: assert property (
        rx_loop && !tx_loop && fifo_level == 5'h00 && rx_valid_i && rx_ready_o
        && $stable(ctrl)
        |=> tx_valid_o && tx_data_o == $past(rx_data_i) && !dac_take)
        else $error("received word not looped to transmit");

    tx_loop_a: assert property (
        tx_loop && !rx_comp_on && !force_byte_word && fifo_out.valid && dac_in_ready
        ##1 $stable(ctrl)
        |-> dac_valid_o && !tx_valid_o
        && dac_data_o == ($past(fifo_out.data[31:16]) & $past(len_mask[31:16])))
        else $error("transmit word not looped to converter");

    mu_expand_a: assert property (
        dac_take && rx_mode == ACL_COMP_MU && dac_src[31:24] == ACL_MU_INV
        |=> dac_valid_o && dac_data_o == 16'h0000)
        else $error("mu-law zero code not expanded to zero");

    lin_pass_a: assert property (
        adc_take && tx_mode == ACL_COMP_OFF && !force_byte_word
        && interface_word_length == 2'h0
        |-> fifo_in.data == {adc_data_i, 16'h0000})
        else $error("linear sample not passed unchanged");

    mu_neg_a: assert property (
        adc_take && tx_mode == ACL_COMP_MU && adc_data_i == 16'hf000
        |-> fifo_in.data[31:24] == 8'h2f)
        else $error("mu-law negative code wrong");

    a_peak_a: assert property (
        adc_take && tx_mode == ACL_COMP_A && adc_data_i == 16'h7fff
        |-> fifo_in.data[31:24] == 8'haa)
        else $error("A-law full scale not in top segment");

    a_expand_a: assert property (
        dac_take && rx_mode == ACL_COMP_A && dac_src[31:24] == 8'hd5
        |=> dac_valid_o && dac_data_o == 16'h0008)
        else $error("A-law smallest code not expanded");

    byte_rx_a: assert property (
        dac_take && force_byte_word && !rx_comp_on
        |=> dac_data_o[7:0] == 8'h00)
        else $error("byte mode did not cut received word");

    tx_block_a: assert property (
        tx_loop && !rx_loop |-> !rx_ready_o && !tx_valid_o)
        else $error("interface not cut off in transmit loopback");

    dac_hold_a: assert property (
        dac_valid_o && !dac_ready_i
        |=> dac_valid_o && $stable(dac_data_o))
        else $error("converter word changed while stalled");

    wb_ack_a: assert property (
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Wishbone ack not a one-cycle answer");

endmodule

// File: logic/acl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module acl_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    acl_stream_if.snk                     in_s,
    acl_stream_if.src                     out_s,
    output logic [$clog2(DEPTH):0]        level_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    assign in_s.ready  = (level_o != (AW+1)'(DEPTH));
    assign out_s.valid = (level_o != '0);
    assign out_s.data  = mem[rd_ptr];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            level_o <= '0;
        end else begin
            wr_ptr  <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr  <= pop ? rd_ptr + 1'b1 : rd_ptr;
            level_o <= level_o + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: logic/acl_g711.sv
// Segmented mu-law / A-law compressor and expander, combinational.
// Assumes 16-bit two's complement linear samples.
`timescale 1ns/1ps
module acl_g711
    import acl_pkg::*;
(
    input  wire logic        enc_alaw_i,
    input  wire logic [15:0] lin_i,
    output logic      [7:0]  code_o,
    input  wire logic        dec_alaw_i,
    input  wire logic [7:0]  code_i,
    output logic      [15:0] lin_o
);
    // Highest set bit among m[lo+7:lo+1], relative to lo; 0 if none
    function automatic logic [2:0] top_seg(input logic [12:0] m, input int unsigned lo);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (m[lo+i]) s = 3'(i);
        end
        return s;
    endfunction

    logic        neg;
    logic [13:0] mu_s;
    logic [13:0] mu_abs;
    logic [12:0] mu_mag;
    logic [2:0]  mu_seg;
    logic [3:0]  mu_man;
    logic [12:0] a_s;
    logic [11:0] a_mag;
    logic [2:0]  a_seg;
    logic [3:0]  a_man;
    logic [7:0]  u;
    logic [15:0] mu_t;
    logic [7:0]  a;
    logic [15:0] a_t;

    assign neg    = lin_i[15];
    assign mu_s   = lin_i[15:2];
    assign mu_abs = neg ? 14'(-mu_s) : mu_s;
    assign mu_mag = 13'((mu_abs > ACL_MU_CLIP ? ACL_MU_CLIP : mu_abs) + ACL_MU_BIAS);
    assign mu_seg = top_seg(mu_mag, 5);
    assign mu_man = 4'(mu_mag >> ({1'b0, mu_seg} + 4'h1));
    assign a_s    = lin_i[15:3];
    assign a_mag  = neg ? ~a_s[11:0] : a_s[11:0];
    assign a_seg  = top_seg({1'b0, a_mag}, 4);
    assign a_man  = (a_seg == 3'h0) ? a_mag[4:1] : 4'(a_mag >> a_seg);
    // Sign, segment, mantissa, then inverted for the line
    assign code_o = enc_alaw_i ? ({~neg, a_seg, a_man} ^ ACL_A_INV)
                               : ({neg, mu_seg, mu_man} ^ ACL_MU_INV);

    // Expansion back to 16-bit linear
    assign u     = code_i ^ ACL_MU_INV;
    assign mu_t  = ((16'(u[3:0]) << 3) + ACL_MU_DBIAS) << u[6:4];
    assign a     = code_i ^ ACL_A_INV;
    assign a_t   = (a[6:4] == 3'h0) ? (16'(a[3:0]) << 4) + ACL_A_SEG0
                 : ((16'(a[3:0]) << 4) + ACL_A_SEG1) << (a[6:4] - 3'h1);
    assign lin_o = dec_alaw_i ? (a[7] ? a_t : 16'(-a_t))
                              : (u[7] ? 16'(ACL_MU_DBIAS - mu_t) : 16'(mu_t - ACL_MU_DBIAS));
endmodule
